/* File: adcs_pkg.sv */
package adcs_pkg;
    // ----------------------------------------
    // Widths and counts
    // ----------------------------------------
    localparam int RES_W = 16;
    localparam int CHAIN_DELAY = 16;
    localparam logic [4:0] BIT_LAST = 5'h10;
    localparam logic [3:0] WR_LAST = 4'hf;
    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [15:0] SHIFT_RST = 16'h0000;
    localparam logic [15:0] WORD_RST = 16'h0000;
    localparam logic [4:0] CNT_RST = 5'h10;
    localparam logic [3:0] WR_CNT_RST = 4'h0;
    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [0:0] {
        ADCS_CHAIN = 1'b0,
        ADCS_CS = 1'b1
    } adcs_mode_e;
    typedef struct packed {
        logic strobe;
        logic sck;
        logic serial_data_input;
    } adcs_pins_s;
    typedef struct packed {
        logic valid;
        logic [15:0] word;
    } adcs_word_s;
endpackage : adcs_pkg

/* File: adcs_serial.sv */
// How it works
// [RL1] Strobe rise starts conversion, latches mode
// [RL2] Data input low at rise: daisy-chain
// [RL3] Data input high at rise: chip-select
// [RL4] Chip-select: drive only while strobe/input low
// [RL5] Daisy-chain: results read while strobe high
// [RL6] Daisy-chain: input reaches output 16 clocks later
// [RL7] Low enable at completion arms busy indicator
// [RL8] Strobe low: capture 16-bit word, rising clock
// [RL9] Selected device shifts result on serial clock
// [RL10] Chip-select: most significant bit first
// [RL11] Output bits change after falling clock edge
// [RL12] Chip-select: release after disable or last bit
// [RL13] Completed result loads output shift register
// [RL14] Host clocks only after mode-select strobe edge
`timescale 1ns/1ps
module adcs_serial #(
    parameter int RES_WIDTH = 16
) (
    input wire logic CORE_CLK,
    input wire logic RSTN,
    input wire logic CLK_EN,
    input wire adcs_pkg::adcs_pins_s PINS,
    input wire logic CONV_DONE,
    input wire logic [15:0] CONV_RESULT,
    output logic CONV_START,
    output logic CONV_BUSY,
    output adcs_pkg::adcs_mode_e MODE,
    output logic SERIAL_DATA_OUTPUT,
    output logic SDO_OE_N,
    output adcs_pkg::adcs_word_s WRITE
);
    import adcs_pkg::*;

    // ----------------------------------------
    // Pin synchronisers and edge detection
    // ----------------------------------------
    adcs_pins_s pins_s1_reg;
    adcs_pins_s pins_s2_reg;
    logic strobe_d_reg;
    logic sck_d_reg;
    logic strobe_s;
    logic sdi_s;
    logic strobe_rise;
    logic strobe_fall;
    logic sck_rise;
    logic sck_fall;

    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            pins_s1_reg <= '0;
            pins_s2_reg <= '0;
            strobe_d_reg <= 1'b0;
            sck_d_reg <= 1'b0;
        end else if (CLK_EN) begin
            pins_s1_reg <= PINS;
            pins_s2_reg <= pins_s1_reg;
            strobe_d_reg <= pins_s2_reg.strobe;
            sck_d_reg <= pins_s2_reg.sck;
        end
    end

    assign strobe_s = pins_s2_reg.strobe;
    assign sdi_s = pins_s2_reg.serial_data_input;
    assign strobe_rise = strobe_s && !strobe_d_reg;
    assign strobe_fall = !strobe_s && strobe_d_reg;
    assign sck_rise = pins_s2_reg.sck && !sck_d_reg;
    assign sck_fall = !pins_s2_reg.sck && sck_d_reg;

    // ----------------------------------------
    // Conversion start and interface mode
    // ----------------------------------------
    adcs_mode_e mode_reg;
    logic start_reg;
    logic busy_reg;

    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            mode_reg <= ADCS_CS;
            start_reg <= 1'b0;
        end else if (CLK_EN) begin
            start_reg <= strobe_rise; // [RL1]
            if (strobe_rise) begin
                mode_reg <= sdi_s ? ADCS_CS : ADCS_CHAIN; // [RL1] [RL2] [RL3]
            end
        end
    end

    // A new start wins over a completion in the same cycle
    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            busy_reg <= 1'b0;
        end else if (CLK_EN) begin
            if (strobe_rise) begin
                busy_reg <= 1'b1;
            end else if (CONV_DONE) begin
                busy_reg <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Output enable tracking
    // ----------------------------------------
    logic cs_en;
    logic cs_en_d_reg;
    logic busy_ind_reg;
    logic [4:0] bit_cnt_reg;
    logic shift_en;

    assign cs_en = (mode_reg == ADCS_CS) && (!strobe_s || !sdi_s); // [RL4]
    // The fall that ends the busy flag is not a data bit
    assign shift_en = sck_fall && !busy_ind_reg;

    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            cs_en_d_reg <= 1'b0;
        end else if (CLK_EN) begin
            cs_en_d_reg <= cs_en;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            busy_ind_reg <= 1'b0;
        end else if (CLK_EN) begin
            if (CONV_DONE) begin
                busy_ind_reg <= cs_en; // [RL7]
            end else if (sck_fall || strobe_rise) begin
                busy_ind_reg <= 1'b0;
            end
        end
    end

    // Bit count restarts whenever the output is newly enabled
    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            bit_cnt_reg <= CNT_RST;
        end else if (CLK_EN) begin
            if (strobe_rise || (cs_en && !cs_en_d_reg)) begin
                bit_cnt_reg <= 5'h00;
            end else if (shift_en && bit_cnt_reg != BIT_LAST) begin
                bit_cnt_reg <= bit_cnt_reg + 5'h01;
            end
        end
    end

    // ----------------------------------------
    // Result shift register and chain path
    // ----------------------------------------
    logic [RES_WIDTH-1:0] shift_reg;
    logic sdi_cap_reg;

    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            sdi_cap_reg <= 1'b0;
        end else if (CLK_EN && sck_rise) begin
            sdi_cap_reg <= sdi_s; // [RL6]
        end
    end

    // Serving as a 16-stage delay line keeps the chain path free
    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            shift_reg <= SHIFT_RST[RES_WIDTH-1:0];
        end else if (CLK_EN) begin
            if (CONV_DONE) begin
                shift_reg <= CONV_RESULT[RES_WIDTH-1:0]; // [RL13]
            end else if (shift_en) begin
                shift_reg <= {shift_reg[RES_WIDTH-2:0], sdi_cap_reg}; // [RL6] [RL11]
            end
        end
    end

    // ----------------------------------------
    // Serial output pin
    // ----------------------------------------
    logic sdo_next;
    logic oe_n_next;
    logic sdo_reg;
    logic oe_n_reg;

    always_comb begin
        if (mode_reg == ADCS_CS) begin
            if (busy_ind_reg) begin
                sdo_next = 1'b1;
            end else if (busy_reg) begin
                sdo_next = 1'b0;
            end else begin
                sdo_next = shift_reg[RES_WIDTH-1]; // [RL9] [RL10]
            end
            oe_n_next = !(cs_en && bit_cnt_reg != BIT_LAST); // [RL4] [RL12]
        end else begin
            sdo_next = shift_reg[RES_WIDTH-1]; // [RL9]
            oe_n_next = !strobe_s; // [RL5]
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            sdo_reg <= 1'b0;
            oe_n_reg <= 1'b1;
        end else if (CLK_EN) begin
            sdo_reg <= sdo_next;
            oe_n_reg <= oe_n_next;
        end
    end

    // ----------------------------------------
    // Programming word capture
    // ----------------------------------------
    logic [15:0] wr_shift_reg;
    logic [3:0] wr_cnt_reg;
    adcs_word_s wr_out_reg;

    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            wr_shift_reg <= WORD_RST;
            wr_cnt_reg <= WR_CNT_RST;
            wr_out_reg <= '0;
        end else if (CLK_EN) begin
            wr_out_reg.valid <= 1'b0;
            if (strobe_fall) begin
                wr_cnt_reg <= WR_CNT_RST;
            end else if (!strobe_s && sck_rise) begin
                wr_shift_reg <= {wr_shift_reg[14:0], sdi_s}; // [RL8]
                wr_cnt_reg <= wr_cnt_reg + 4'h1;
                if (wr_cnt_reg == WR_LAST) begin
                    wr_out_reg.valid <= 1'b1; // [RL8]
                    wr_out_reg.word <= {wr_shift_reg[14:0], sdi_s};
                end
            end
        end
    end

    assign CONV_START = start_reg;
    assign CONV_BUSY = busy_reg;
    assign MODE = mode_reg;
    assign SERIAL_DATA_OUTPUT = sdo_reg;
    assign SDO_OE_N = oe_n_reg;
    assign WRITE = wr_out_reg;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RSTN || !CLK_EN);

    mode_chain_a: assert property ( // [RL2]
        strobe_rise && !sdi_s |=> mode_reg == ADCS_CHAIN)
        else $error("Chain mode not latched");
    mode_cs_a: assert property ( // [RL3]
        strobe_rise && sdi_s |=> mode_reg == ADCS_CS)
        else $error("Chip-select mode not latched");
    start_pulse_a: assert property ( // [RL1]
        strobe_rise |=> CONV_START && CONV_BUSY)
        else $error("Conversion not started");
    cs_release_a: assert property ( // [RL4]
        mode_reg == ADCS_CS && !cs_en && $stable(mode_reg) |=> SDO_OE_N)
        else $error("Output driven while deselected");
    chain_drive_a: assert property ( // [RL5]
        mode_reg == ADCS_CHAIN && strobe_s |=> !SDO_OE_N)
        else $error("Chain output not driven");
    result_load_a: assert property ( // [RL13]
        CONV_DONE |=> shift_reg == $past(CONV_RESULT))
        else $error("Result not loaded");
    shift_step_a: assert property ( // [RL6]
        shift_en && !CONV_DONE |=> shift_reg[RES_WIDTH-1:1] ==
            $past(shift_reg[RES_WIDTH-2:0]) && shift_reg[0] ==
            $past(sdi_cap_reg))
        else $error("Shift step wrong");
    msb_first_a: assert property ( // [RL10]
        mode_reg == ADCS_CS && !busy_ind_reg && !busy_reg && !CONV_DONE
            |=> SERIAL_DATA_OUTPUT == $past(shift_reg[RES_WIDTH-1]))
        else $error("Output bit not shift register top");
    last_bit_a: assert property ( // [RL12]
        mode_reg == ADCS_CS && bit_cnt_reg == BIT_LAST && !strobe_rise
            && !(cs_en && !cs_en_d_reg) |=> SDO_OE_N)
        else $error("Output not released after last bit");
    busy_arm_a: assert property ( // [RL7]
        CONV_DONE && cs_en |=> busy_ind_reg ##1 SERIAL_DATA_OUTPUT)
        else $error("Busy indicator not armed");
    write_word_a: assert property ( // [RL8]
        !strobe_s && !strobe_fall && sck_rise && wr_cnt_reg == WR_LAST
            |=> WRITE.valid)
        else $error("Programming word not delivered");

    chain_read_c: cover property (mode_reg == ADCS_CHAIN && shift_en);
    cs_read_c: cover property (bit_cnt_reg == BIT_LAST ##1 SDO_OE_N);
    busy_ind_c: cover property (busy_ind_reg ##1 !busy_ind_reg);
    write_c: cover property (WRITE.valid);
endmodule : adcs_serial

/* File: adcs_host.sv */
`timescale 1ns/1ps
module adcs_host (
    input wire logic CORE_CLK,
    input wire logic SDO_LINE,
    output adcs_pkg::adcs_pins_s PINS
);
    import adcs_pkg::*;
    initial PINS = '0;
    // Half a serial clock period, 80 ns, moved on falling edges
    task automatic half();
        repeat (8) @(negedge CORE_CLK);
    endtask : half
    // Serial data level at the strobe rise picks the mode
    task automatic start(input logic cs);
        PINS.serial_data_input = cs;
        half();
        PINS.strobe = 1'b1;
        half(); // No clocks before the mode edge has settled
    endtask : start
    task automatic sel(input logic v);
        PINS.strobe = v;
        half();
    endtask : sel
    // Word bits leave msb first; output sampled at each rise
    task automatic xfer(input int n, input logic [31:0] w,
                        output logic [31:0] r);
        r = '0;
        for (int i = n - 1; i >= 0; i--) begin
            PINS.serial_data_input = w[i];
            half();
            PINS.sck = 1'b1;
            r[i] = SDO_LINE;
            half();
            PINS.sck = 1'b0;
        end
        half();
    endtask : xfer
endmodule : adcs_host

/* File: tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    import adcs_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic clk_en = 1'b1;
    logic done = 1'b0;
    logic [15:0] res = 16'h0000;
    logic start_o, busy_o, serial_data_output, oe_n;
    logic last = 1'b0;
    adcs_mode_e mode;
    adcs_word_s wr;
    adcs_pins_s pins;
    logic [31:0] r;
    int nst = 0;
    int nw = 0;
    int n_mismatch = 0;
    int samples_checked = 0;
    // Result in the upper half, programming word in the lower half
    logic [31:0] rows [4] = '{32'h8001_a5c3, 32'h0000_ffff,
                              32'hffff_0000, 32'h1234_0001};
    // Released line shows the inverse of its last driven level
    wire logic line = oe_n ? ~last : serial_data_output;
    initial forever #5 clk = ~clk;
    always @(posedge clk) begin
        if (!oe_n) last <= serial_data_output;
        if (start_o === 1'b1) nst <= nst + 1;
        if (wr.valid === 1'b1) nw <= nw + 1;
    end
    adcs_serial dut_u (.CORE_CLK(clk), .RSTN(rstn), .CLK_EN(clk_en),
        .PINS(pins), .CONV_DONE(done), .CONV_RESULT(res),
        .CONV_START(start_o), .CONV_BUSY(busy_o), .MODE(mode),
        .SERIAL_DATA_OUTPUT(serial_data_output), .SDO_OE_N(oe_n), .WRITE(wr));
    adcs_host host_u (.CORE_CLK(clk), .SDO_LINE(line), .PINS(pins));
    task automatic end_of_test();
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string msg);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t %s", $time, msg);
        end
    endtask : chk
    // Converter core completes one cycle-wide pulse later
    task automatic conv(input logic [15:0] v, input int ns0);
        chk(nst, ns0 + 1, "start pulse");
        chk(busy_o, 1'b1, "busy");
        @(negedge clk);
        res = v;
        done = 1'b1;
        @(negedge clk);
        done = 1'b0;
        repeat (2) @(negedge clk);
        chk(busy_o, 1'b0, "idle");
    endtask : conv
    initial begin
        #100_000;
        n_mismatch++;
        end_of_test();
    end
    initial begin
        repeat (3) @(negedge clk);
        rstn = 1'b1;
        chk(oe_n, 1'b1, "reset release");
        chk(mode, ADCS_CS, "reset mode");
        for (int i = 0; i < 4; i++) begin
            host_u.start(1'b1);
            conv(rows[i][31:16], i);
            chk(mode, ADCS_CS, "cs mode");
            chk(oe_n, 1'b1, "cs disabled");
            host_u.sel(1'b0);
            chk(oe_n, 1'b0, "cs enabled");
            host_u.xfer(16, {16'h0000, rows[i][15:0]}, r);
            chk(r[15:0], rows[i][31:16], "cs data");
            chk(oe_n, 1'b1, "cs released");
            chk(wr.word, rows[i][15:0], "write word");
            chk(nw, i + 1, "write pulse");
        end
        // Strobe rise while frozen must wait for the enable
        clk_en = 1'b0;
        host_u.start(1'b1);
        chk(nst, 4, "frozen start");
        chk(busy_o, 1'b0, "frozen busy");
        clk_en = 1'b1;
        host_u.half();
        // Enabled before completion: indicator then result
        host_u.sel(1'b0);
        chk(serial_data_output, 1'b0, "busy level");
        conv(16'h6d39, 4);
        chk(serial_data_output, 1'b1, "done level");
        host_u.xfer(17, 32'h0000_0000, r);
        chk(r[16:0], {1'b1, 16'h6d39}, "busy read");
        chk(oe_n, 1'b1, "busy released");
        // Chain: result first, then input 16 clocks late
        host_u.start(1'b0);
        chk(mode, ADCS_CHAIN, "chain mode");
        conv(16'hc3a5, 5);
        chk(oe_n, 1'b0, "chain driven");
        host_u.xfer(32, {16'h5a0f, 16'h0000}, r);
        chk(r, 32'hc3a5_5a0f, "chain data");
        host_u.sel(1'b0);
        // Reset in mid-run, strobe low so no false edge follows
        rstn = 1'b0;
        repeat (3) @(negedge clk);
        rstn = 1'b1;
        chk(oe_n, 1'b1, "second reset");
        chk(mode, ADCS_CS, "second reset mode");
        chk(busy_o, 1'b0, "second reset busy");
        repeat (4) @(negedge clk);
        chk(oe_n, 1'b0, "cs enabled after reset");
        chk(nst, 6, "no false start");
        end_of_test();
    end
endmodule : tb_top
